/* File: src/irx_map.svh */
/*
 * Constants of the integer execution block: widths, reset values, stepping.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef IRX_MAP_SVH
`define IRX_MAP_SVH

`define IRX_XLEN        64
`define IRX_GPR_COUNT   32
`define IRX_GPR_AW      5
`define IRX_SHAMT_W     6
`define IRX_PC_RESET    64'h0000_0000_0000_0000
`define IRX_PC_STEP     64'h0000_0000_0000_0004
`define IRX_ZERO_REG    5'h00

`endif

/* File: src/irx_pkg.sv */
/*
 * Types of the integer execution block: operations, muldiv states, stage records.
 * Assumes irx_map.svh is on the include path.
 */
`include "irx_map.svh"

package irx_pkg;

    typedef enum logic [3:0] {
        IRX_OP_NOP                     = 4'h0,
        IRX_OP_ADD                     = 4'h1,
        IRX_OP_SUB                     = 4'h2,
        IRX_OP_AND                     = 4'h3,
        IRX_OP_OR                      = 4'h4,
        IRX_OP_XOR                     = 4'h5,
        IRX_OP_NOR                     = 4'h6,
        IRX_OP_SLL                     = 4'h7,
        IRX_OP_SRL                     = 4'h8,
        IRX_OP_SRA                     = 4'h9,
        IRX_OP_ADDRESS                 = 4'hA,
        IRX_OP_MUL                     = 4'hB,
        IRX_OP_DIV                     = 4'hC,
        IRX_OP_MOVE_FROM_HIGH_RESULT   = 4'hD,
        IRX_OP_MOVE_FROM_LOW_RESULT    = 4'hE
    } irx_op_type;

    typedef enum logic [1:0] {
        IRX_MD_IDLE = 2'b01,
        IRX_MD_BUSY = 2'b10
    } irx_md_state_type;

    typedef struct packed {
        logic                     valid;
        irx_op_type               op;
        logic [`IRX_GPR_AW-1:0]   src_a;
        logic [`IRX_GPR_AW-1:0]   src_b;
        logic [`IRX_GPR_AW-1:0]   dst;
        logic [`IRX_XLEN-1:0]     imm;
    } irx_rd_stage_type;

    typedef struct packed {
        logic                     valid;
        logic [`IRX_GPR_AW-1:0]   dst;
        logic [`IRX_XLEN-1:0]     data;
    } irx_res_stage_type;

    typedef struct packed {
        irx_rd_stage_type         rd;
        irx_res_stage_type        mem;
        irx_res_stage_type        wb;
        irx_res_stage_type        last;
        logic                     addr_valid;
        logic [`IRX_XLEN-1:0]     addr;
        logic [`IRX_XLEN-1:0]     pc;
        irx_md_state_type         md;
        logic                     md_req;
        logic                     md_divide;
        logic [`IRX_XLEN-1:0]     md_a;
        logic [`IRX_XLEN-1:0]     md_b;
        logic [`IRX_XLEN-1:0]     high;
        logic [`IRX_XLEN-1:0]     low;
    } irx_core_state_type;

    typedef struct packed {
        logic [`IRX_GPR_COUNT-1:0][`IRX_XLEN-1:0] regs;
        logic [`IRX_XLEN-1:0]                     rdata_a;
        logic [`IRX_XLEN-1:0]                     rdata_b;
    } irx_gpr_state_type;

endpackage

/* File: src/irx_gpr_mem.sv */
/*
 * General-purpose register storage: two registered read ports, one write port.
 * Assumes the caller handles register zero and forwarding; a read in the cycle
 * of a write to the same entry returns the old value.
 */
`timescale 1ns/1ps
`include "irx_map.svh"

module irx_gpr_mem (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   ce,
    input  wire logic [`IRX_GPR_AW-1:0] rd_addr_a,
    input  wire logic [`IRX_GPR_AW-1:0] rd_addr_b,
    output logic      [`IRX_XLEN-1:0]   rd_data_a,
    output logic      [`IRX_XLEN-1:0]   rd_data_b,
    input  wire logic                   wr_en,
    input  wire logic [`IRX_GPR_AW-1:0] wr_addr,
    input  wire logic [`IRX_XLEN-1:0]   wr_data
);

    irx_pkg::irx_gpr_state_type s_q;
    irx_pkg::irx_gpr_state_type s_d;

    always_comb begin
        s_d = s_q;
        s_d.rdata_a = s_q.regs[rd_addr_a];
        s_d.rdata_b = s_q.regs[rd_addr_b];
        if (wr_en) begin
            s_d.regs[wr_addr] = wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign rd_data_a = s_q.rdata_a;
    assign rd_data_b = s_q.rdata_b;

endmodule

/* File: src/irx_core.sv */
/*
 * Integer execution core: operand read, forwarding, adder and logic unit,
 * multiply/divide result registers and program counter.
 * Assumes the issuing control presents one instruction per cycle with a
 * valid/ready handshake and an external floating-point unit performs the
 * multiply and divide arithmetic on the same clock.
 */
`timescale 1ns/1ps
`include "irx_map.svh"

// What this block does
// - Instructions pass in order through issue, read, execute, memory and writeback stages.
// - Thirty-two general registers serve alike for integer work and address forming.
// - Every general register, both result registers and the program counter are 64 bits wide.
// - Two read ports and one write port of the register file work in the same cycle.
// - Results not yet written back are forwarded to dependent operands.
// - Logic, shift, add and subtract finish in one execute cycle.
// - The adder does arithmetic and address forming; a separate logic unit does logic and shifts.
// - Integer multiply and divide are sent to the floating-point hardware.
// - Multiply and divide results land only in the high and low result registers.
// - Two move operations copy the high or low result register into a general register.
module irx_core (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   ce,
    input  wire logic                   issue_valid,
    input  wire irx_pkg::irx_op_type    issue_op,
    input  wire logic [`IRX_GPR_AW-1:0] issue_src_a,
    input  wire logic [`IRX_GPR_AW-1:0] issue_src_b,
    input  wire logic [`IRX_GPR_AW-1:0] issue_dst,
    input  wire logic [`IRX_XLEN-1:0]   issue_imm,
    output logic                        issue_ready,
    input  wire logic                   pc_load,
    input  wire logic [`IRX_XLEN-1:0]   pc_value,
    output logic      [`IRX_XLEN-1:0]   program_counter,
    output logic                        muldiv_req_valid,
    output logic                        muldiv_req_divide,
    output logic      [`IRX_XLEN-1:0]   muldiv_req_a,
    output logic      [`IRX_XLEN-1:0]   muldiv_req_b,
    input  wire logic                   muldiv_done,
    input  wire logic [`IRX_XLEN-1:0]   muldiv_high_in,
    input  wire logic [`IRX_XLEN-1:0]   muldiv_low_in,
    output logic      [`IRX_XLEN-1:0]   muldiv_high_result,
    output logic      [`IRX_XLEN-1:0]   muldiv_low_result,
    output logic                        mem_addr_valid,
    output logic      [`IRX_XLEN-1:0]   mem_addr,
    output logic                        wb_valid,
    output logic      [`IRX_GPR_AW-1:0] wb_dst,
    output logic      [`IRX_XLEN-1:0]   wb_data
);

    irx_pkg::irx_core_state_type s_q;
    irx_pkg::irx_core_state_type s_d;

    logic [`IRX_XLEN-1:0] raw_a;
    logic [`IRX_XLEN-1:0] raw_b;
    logic [`IRX_XLEN-1:0] opnd_a;
    logic [`IRX_XLEN-1:0] opnd_b;
    logic [`IRX_XLEN-1:0] sum;
    logic [`IRX_XLEN-1:0] logic_res;
    logic [`IRX_XLEN-1:0] result;
    logic                 writes_gpr;
    logic                 issue_is_move;
    logic                 issue_is_muldiv;
    logic                 rd_is_muldiv;
    logic                 accept;

    function automatic logic is_muldiv(input irx_pkg::irx_op_type op);
        is_muldiv = (op == irx_pkg::IRX_OP_MUL) || (op == irx_pkg::IRX_OP_DIV);
    endfunction

    // youngest producer wins; the last slot covers a write landing on the read edge
    function automatic logic [`IRX_XLEN-1:0] forward(
        input logic [`IRX_GPR_AW-1:0]       addr,
        input logic [`IRX_XLEN-1:0]         raw,
        input irx_pkg::irx_core_state_type  s
    );
        if (addr == `IRX_ZERO_REG) begin
            forward = '0;
        end else if (s.mem.valid && s.mem.dst == addr) begin
            forward = s.mem.data;
        end else if (s.wb.valid && s.wb.dst == addr) begin
            forward = s.wb.data;
        end else if (s.last.valid && s.last.dst == addr) begin
            forward = s.last.data;
        end else begin
            forward = raw;
        end
    endfunction

    // register zero is never written, so its storage stays at reset value
    irx_gpr_mem u_gpr (
        .clk       (clk),
        .reset     (reset),
        .ce        (ce),
        .rd_addr_a (issue_src_a),
        .rd_addr_b (issue_src_b),
        .rd_data_a (raw_a),
        .rd_data_b (raw_b),
        .wr_en     (s_q.wb.valid),
        .wr_addr   (s_q.wb.dst),
        .wr_data   (s_q.wb.data)
    );

    always_comb begin
        s_d = s_q;

        issue_is_move = (issue_op == irx_pkg::IRX_OP_MOVE_FROM_HIGH_RESULT) ||
                        (issue_op == irx_pkg::IRX_OP_MOVE_FROM_LOW_RESULT);
        issue_is_muldiv = is_muldiv(issue_op);
        rd_is_muldiv = s_q.rd.valid && is_muldiv(s_q.rd.op);
        // stall moves and further multiplies/divides while one is in flight; also keeps one outstanding at a time
        issue_ready = !((issue_is_move || issue_is_muldiv) &&
                        (s_q.md == irx_pkg::IRX_MD_BUSY || rd_is_muldiv));
        accept = issue_valid && issue_ready;

        opnd_a = forward(s_q.rd.src_a, raw_a, s_q);
        opnd_b = forward(s_q.rd.src_b, raw_b, s_q);

        // adder: arithmetic and address forming share one carry chain
        case (s_q.rd.op)
            irx_pkg::IRX_OP_SUB: sum = opnd_a - opnd_b;
            irx_pkg::IRX_OP_ADDRESS: sum = opnd_a + s_q.rd.imm;
            default: sum = opnd_a + opnd_b;
        endcase

        case (s_q.rd.op)
            irx_pkg::IRX_OP_AND: logic_res = opnd_a & opnd_b;
            irx_pkg::IRX_OP_OR:  logic_res = opnd_a | opnd_b;
            irx_pkg::IRX_OP_XOR: logic_res = opnd_a ^ opnd_b;
            irx_pkg::IRX_OP_NOR: logic_res = ~(opnd_a | opnd_b);
            irx_pkg::IRX_OP_SLL: logic_res = opnd_a << opnd_b[`IRX_SHAMT_W-1:0];
            irx_pkg::IRX_OP_SRL: logic_res = opnd_a >> opnd_b[`IRX_SHAMT_W-1:0];
            irx_pkg::IRX_OP_SRA: logic_res = $signed(opnd_a) >>> opnd_b[`IRX_SHAMT_W-1:0];
            default:             logic_res = '0;
        endcase

        writes_gpr = 1'b1;
        case (s_q.rd.op)
            irx_pkg::IRX_OP_ADD,
            irx_pkg::IRX_OP_SUB: begin
                result = sum;
            end
            irx_pkg::IRX_OP_MOVE_FROM_HIGH_RESULT: begin
                result = s_q.high;
            end
            irx_pkg::IRX_OP_MOVE_FROM_LOW_RESULT: begin
                result = s_q.low;
            end
            irx_pkg::IRX_OP_NOP,
            irx_pkg::IRX_OP_ADDRESS,
            irx_pkg::IRX_OP_MUL,
            irx_pkg::IRX_OP_DIV: begin
                result = '0;
                writes_gpr = 1'b0;
            end
            default: begin
                result = logic_res;
            end
        endcase

        // in-order shift of the pipeline: read -> execute -> memory -> writeback
        s_d.last = s_q.wb;
        s_d.wb = s_q.mem;
        s_d.mem.valid = s_q.rd.valid && writes_gpr && (s_q.rd.dst != `IRX_ZERO_REG);
        s_d.mem.dst = s_q.rd.dst;
        s_d.mem.data = result;
        s_d.addr_valid = s_q.rd.valid && (s_q.rd.op == irx_pkg::IRX_OP_ADDRESS);
        if (s_q.rd.valid && s_q.rd.op == irx_pkg::IRX_OP_ADDRESS) begin
            s_d.addr = sum;
        end

        s_d.rd.valid = accept;
        s_d.rd.op = issue_op;
        s_d.rd.src_a = issue_src_a;
        s_d.rd.src_b = issue_src_b;
        s_d.rd.dst = issue_dst;
        s_d.rd.imm = issue_imm;

        if (pc_load) begin
            s_d.pc = pc_value;
        end else if (accept) begin
            s_d.pc = s_q.pc + `IRX_PC_STEP;
        end

        s_d.md_req = 1'b0;
        case (s_q.md)
            irx_pkg::IRX_MD_IDLE: begin
                if (rd_is_muldiv) begin
                    s_d.md = irx_pkg::IRX_MD_BUSY;
                    s_d.md_req = 1'b1;
                    s_d.md_divide = (s_q.rd.op == irx_pkg::IRX_OP_DIV);
                    s_d.md_a = opnd_a;
                    s_d.md_b = opnd_b;
                end
            end
            irx_pkg::IRX_MD_BUSY: begin
                if (muldiv_done) begin
                    s_d.md = irx_pkg::IRX_MD_IDLE;
                    s_d.high = muldiv_high_in;
                    s_d.low = muldiv_low_in;
                end
            end
            default: begin
                s_d.md = irx_pkg::IRX_MD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.pc <= `IRX_PC_RESET;
            s_q.md <= irx_pkg::IRX_MD_IDLE;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign program_counter    = s_q.pc;
    assign muldiv_req_valid   = s_q.md_req;
    assign muldiv_req_divide  = s_q.md_divide;
    assign muldiv_req_a       = s_q.md_a;
    assign muldiv_req_b       = s_q.md_b;
    assign muldiv_high_result = s_q.high;
    assign muldiv_low_result  = s_q.low;
    assign mem_addr_valid     = s_q.addr_valid;
    assign mem_addr           = s_q.addr;
    assign wb_valid           = s_q.wb.valid;
    assign wb_dst             = s_q.wb.dst;
    assign wb_data            = s_q.wb.data;

endmodule

/* File: testbench/irx_core_props.sv */
/*
 * Port-level checks of the integer execution core.
 * Assumes one clock, synchronous active-high reset; bound at the foot.
 */
`timescale 1ns/1ps

module irx_core_props (
    input wire logic                clk,
    input wire logic                reset,
    input wire logic                ce,
    input wire logic                issue_valid,
    input wire irx_pkg::irx_op_type issue_op,
    input wire logic [4:0]          issue_dst,
    input wire logic                issue_ready,
    input wire logic                pc_load,
    input wire logic [63:0]         program_counter,
    input wire logic                muldiv_req_valid,
    input wire logic                muldiv_done,
    input wire logic [63:0]         muldiv_high_in,
    input wire logic [63:0]         muldiv_low_in,
    input wire logic [63:0]         muldiv_high_result,
    input wire logic [63:0]         muldiv_low_result,
    input wire logic                mem_addr_valid,
    input wire logic                wb_valid,
    input wire logic [4:0]          wb_dst
);
    logic taken;
    logic busy_q;

    assign taken = ce && issue_valid && issue_ready;

    // busy from the request pulse until the unit's answer
    always_ff @(posedge clk) begin
        busy_q <= !reset && (muldiv_req_valid || (busy_q && !muldiv_done));
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    AST_WB_ZERO: assert property (wb_valid |-> wb_dst != 5'h00)
        else $error("write-back to register zero");
    AST_ALU_LAT: assert property (taken && issue_op inside {[4'h1:4'h9]} && issue_dst != 5'h00
        |-> ##3 wb_valid && wb_dst == $past(issue_dst, 3)) else $error("alu result late or misrouted");
    AST_ADDR_LAT: assert property (taken && issue_op == 4'hA |-> ##2 mem_addr_valid)
        else $error("address not formed in time");
    AST_REQ_LAT: assert property (taken && issue_op inside {4'hB, 4'hC}
        |-> ##2 muldiv_req_valid ##1 !muldiv_req_valid) else $error("muldiv request pulse wrong");
    AST_NO_WB_MD: assert property (taken && issue_op inside {4'hB, 4'hC} |-> ##3 !wb_valid)
        else $error("muldiv wrote a general register");
    AST_HILO_VAL: assert property (busy_q && muldiv_done |=> muldiv_high_result == $past(muldiv_high_in)
        && muldiv_low_result == $past(muldiv_low_in)) else $error("result registers not loaded");
    AST_STALL: assert property ((busy_q || muldiv_req_valid) && issue_op inside {4'hD, 4'hE} |-> !issue_ready)
        else $error("move accepted while muldiv busy");
    AST_PC_STEP: assert property (taken && !pc_load |=> program_counter == $past(program_counter) + 64'h4)
        else $error("program counter did not step");
endmodule

bind irx_core irx_core_props props_u (.clk, .reset, .ce, .issue_valid, .issue_op, .issue_dst, .issue_ready,
    .pc_load, .program_counter, .muldiv_req_valid, .muldiv_done, .muldiv_high_in, .muldiv_low_in,
    .muldiv_high_result, .muldiv_low_result, .mem_addr_valid, .wb_valid, .wb_dst);

/* File: testbench/irx_fpu_model.sv */
/*
 * Far-side model of the floating-point unit doing integer multiply and divide.
 * Assumes one request at a time; answers 1 to 7 cycles after the pulse.
 */
`timescale 1ns/1ps

module irx_fpu_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        req_valid,
    input  wire logic        req_divide,
    input  wire logic [63:0] req_a,
    input  wire logic [63:0] req_b,
    output logic             done,
    output logic      [63:0] high,
    output logic      [63:0] low
);
    logic [127:0] res;
    int           wait_n = -1;

    initial {done, high, low} = 129'h0;

    always @(posedge clk) begin
        #1;
        done = 1'b0;
        {high, low} = ~{high, low}; // garbage outside the done cycle
        if (reset)
            wait_n = -1;
        else if (req_valid) begin
            wait_n = $urandom_range(6, 0);
            res = req_divide ? {(req_b == 0) ? req_a : req_a % req_b, (req_b == 0) ? ~64'h0 : req_a / req_b}
                             : req_a * req_b;
        end else if (wait_n > 0)
            wait_n--;
        else if (wait_n == 0) begin
            done = 1'b1;
            {high, low} = res;
            wait_n = -1;
        end
    end
endmodule

/* File: testbench/test_integer_regfile_alu_hilo.sv */
/*
 * Random instruction stream against a register-level model of the core.
 * Assumes irx_core, the unit model and the checker are compiled first.
 */
`timescale 1ns/1ps

module test_integer_regfile_alu_hilo;
    logic                clk, reset, ce, issue_valid, issue_ready, pc_load, mem_addr_valid, wb_valid;
    logic                muldiv_req_valid, muldiv_req_divide, muldiv_done;
    irx_pkg::irx_op_type issue_op;
    logic [4:0]          issue_src_a, issue_src_b, issue_dst, wb_dst;
    logic [63:0]         issue_imm, pc_value, program_counter, muldiv_req_a, muldiv_req_b, muldiv_high_in;
    logic [63:0]         muldiv_low_in, muldiv_high_result, muldiv_low_result, mem_addr, wb_data;
    logic [63:0]         rf [32];
    logic [63:0]         epc, ehi, elo;
    logic [68:0]         wb_q [$];
    logic [63:0]         addr_q [$];
    int                  fail_count, compares, cyc, k;

    irx_core dut_u (.clk, .reset, .ce, .issue_valid, .issue_op, .issue_src_a, .issue_src_b, .issue_dst,
        .issue_imm, .issue_ready, .pc_load, .pc_value, .program_counter, .muldiv_req_valid, .muldiv_req_divide,
        .muldiv_req_a, .muldiv_req_b, .muldiv_done, .muldiv_high_in, .muldiv_low_in, .muldiv_high_result,
        .muldiv_low_result, .mem_addr_valid, .mem_addr, .wb_valid, .wb_dst, .wb_data);
    irx_fpu_model fpu_u (.clk, .reset, .req_valid(muldiv_req_valid), .req_divide(muldiv_req_divide),
        .req_a(muldiv_req_a), .req_b(muldiv_req_b), .done(muldiv_done), .high(muldiv_high_in), .low(muldiv_low_in));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [68:0] got, input logic [68:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pc(input logic [63:0] exp);
        chk({5'h00, program_counter}, {5'h00, exp});
    endtask

    task automatic chk_wb(input logic [68:0] exp);
        chk({wb_dst, wb_data}, exp);
    endtask

    task automatic chk_addr(input logic [63:0] exp);
        chk({5'h00, mem_addr}, {5'h00, exp});
    endtask

    task automatic chk_hilo(input logic high_sel, input logic [63:0] exp);
        chk({5'h00, high_sel ? muldiv_high_result : muldiv_low_result}, {5'h00, exp});
    endtask

    task automatic end_of_test;
        if (fail_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic issue(input logic [3:0] op, input logic [4:0] a, input logic [4:0] b, input logic [4:0] d);
        logic [63:0] x, y, r;
        x = rf[a];
        y = rf[b];
        r = 64'h0;
        issue_valid = 1'b1;
        issue_op = irx_pkg::irx_op_type'(op);
        issue_src_a = a;
        issue_src_b = b;
        issue_dst = d;
        issue_imm = {$urandom, $urandom};
        #1;
        // a hang here is cut by the cycle limit
        while (issue_ready !== 1'b1) begin
            @(posedge clk);
            #2;
        end
        @(posedge clk);
        #1;
        epc = epc + 64'h4;
        chk_pc(epc);
        case (op)
            4'h1: r = x + y;
            4'h2: r = x - y;
            4'h3: r = x & y;
            4'h4: r = x | y;
            4'h5: r = x ^ y;
            4'h6: r = ~(x | y);
            4'h7: r = x << y[5:0];
            4'h8: r = x >> y[5:0];
            4'h9: r = $signed(x) >>> y[5:0];
            4'hA: addr_q.push_back(x + issue_imm);
            4'hB: {ehi, elo} = x * y;
            4'hC: {ehi, elo} = {(y == 0) ? x : x % y, (y == 0) ? ~64'h0 : x / y};
            4'hD: r = ehi;
            4'hE: r = elo;
            default: ;
        endcase
        if (op inside {4'hD, 4'hE})
            chk_hilo(op == 4'hD, r);
        if (op inside {[4'h1:4'h9], 4'hD, 4'hE} && d != 5'h00) begin
            rf[d] = r;
            wb_q.push_back({d, r});
        end
    endtask

    always @(posedge clk) begin
        #1;
        cyc++;
        if (cyc > 20000) begin
            fail_count++;
            end_of_test;
        end
        if (wb_valid === 1'b1)
            chk_wb((wb_q.size() > 0) ? wb_q.pop_front() : ~69'h0);
        if (mem_addr_valid === 1'b1)
            chk_addr((addr_q.size() > 0) ? addr_q.pop_front() : ~64'h0);
    end

    initial begin
        void'($urandom(32'h473C275F));
        {ce, reset, issue_valid, pc_load} = 4'hD;
        issue_op = irx_pkg::IRX_OP_NOP;
        {issue_src_a, issue_src_b, issue_dst} = 15'h0000;
        {issue_imm, pc_value, epc, ehi, elo} = 320'h0;
        {fail_count, compares, cyc} = 96'h0;
        foreach (rf[i])
            rf[i] = 64'h0;
        repeat (6) @(posedge clk);
        #1;
        reset = 1'b0;
        pc_load = 1'b1;
        epc = {$urandom, $urandom} & ~64'h3;
        pc_value = epc;
        @(posedge clk);
        #1;
        pc_load = 1'b0;
        chk_pc(epc);
        issue(4'h6, 5'h00, 5'h00, 5'h01);
        issue(4'h2, 5'h00, 5'h01, 5'h02);
        // random ops over all registers, dependent back to back, with bubbles
        for (int i = 0; i < 600; i++) begin
            k = $urandom_range(15, 0);
            if (k == 15) begin
                issue_valid = 1'b0;
                @(posedge clk);
                #1;
            end else
                issue(4'(k), 5'($urandom), 5'($urandom), 5'($urandom));
        end
        issue_valid = 1'b0;
        repeat (8) @(posedge clk);
        chk(69'(wb_q.size() + addr_q.size()), 69'h0);
        end_of_test;
    end
endmodule
